/* core/hsd_driver_ctrl.sv */
// Purpose: Control logic of one high-side output driver
// Assumes: Wishbone classic slave; source and sensor inputs synchronous to clock
// Notes: Analog stage sits outside; this block drives its gate and limit controls
//
// Behaviour
// R1: Enable low, data read returns the stored data bit.
// R2: Enable high, data read returns the routed source level.
// R3: Entering stop mode clears the output data register.
// R4: Data bit at bit 0; one turns driver on.
// R5: Software waits settling time after enabling before switching on.
// R6: Mask bit 4 ignores over-current for a window after switch-on.
// R7: Mask bit writable only while driver enable is zero.
// R8: Open-load enable bit 2 detects only when enabled and undriven.
// R9: Driver enable at bit 0 biases and enables the stage.
// R10: Slew-current bit 2 limits current about 4 us after switch-on.
// R11: Slew-rate bit 0 limits slew about 8 us after switch-on.
// R12: Both slew bits writable only while driver enable is zero.
// R13: Test register always readable, writable only in special mode.
// R14: Over-current sets flag, holds driver off; write one clears.
// R15: Interrupt requested while flag and interrupt enable are set.
// R16: Stop mode shuts driver down; enable restored after stop.
// R17: Gate is enable AND source AND no unmasked over-current flag.
// R18: Unimplemented bits read zero and ignore writes.
`default_nettype none
module hsd_driver_ctrl
  import hsd_pkg::*;
#(
  parameter int OcMaskWindow = OcMaskCycles
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic specialMode,
  input wire logic stopMode,
  input wire logic sourceSelData,
  input wire logic routedSource,
  input wire logic overcurrentDetect,
  input wire logic openLoadSense,
  output logic driverGate,
  output logic driverBias,
  output logic openLoadActive,
  output logic slewRateLimit,
  output logic slewCurrentLimit,
  output logic [7:0] factoryTest,
  output logic irq
);
  logic outputData_q;
  logic driverEnable_q;
  logic openLoadEnable_q;
  logic ocMaskEnable_q;
  logic slewRate_q;
  logic slewCurrent_q;
  logic [7:0] factoryTest_q;
  logic ocIrqEnable_q;
  logic ocFlag_q;
  logic openLoad_q;
  logic stopMode_q;
  logic gateOn_q;
  logic gateOnPrev_q;
  logic sourceLevel;
  logic switchOn;
  logic maskActive;
  logic rateActive;
  logic currentActive;
  logic access;
  logic wrLow;
  logic [3:0] index;
  logic [7:0] wrByte;
  logic [7:0] rdByte;
  logic mapped;
  logic maskStart;

  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign index = wb_adr_i[5:2];
  assign mapped = wb_adr_i[31:6] == 26'h0 && wb_adr_i[1:0] == 2'b00 && index <= IdxIrqStatus;
  assign wrLow = access && mapped && wb_we_i && wb_sel_i[0];
  assign wrByte = wb_dat_i[7:0];

  // R2 routed level
  assign sourceLevel = sourceSelData ? outputData_q : routedSource;
  assign switchOn = gateOn_q && !gateOnPrev_q;
  // R6 first masked cycle
  // Timer loads one edge after switch-on, so that first cycle is masked here
  assign maskStart = switchOn && ocMaskEnable_q;

  // Bus handshake: one registered answer per request, one cycle after it, error for holes
  always_ff @(posedge clock) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= access && mapped;
      wb_err_o <= access && !mapped;
    end
  end

  // R3 stop clears data
  always_ff @(posedge clock) begin
    if (reset) begin
      outputData_q <= 1'b0;
    end else if (stopMode && !stopMode_q) begin
      outputData_q <= 1'b0;
    // R4 data bit zero
    end else if (wrLow && index == IdxOutputData) begin
      outputData_q <= wrByte[BitOutputData];
    end
  end

  // R9 enable and config
  always_ff @(posedge clock) begin
    if (reset) begin
      driverEnable_q <= 1'b0;
      openLoadEnable_q <= 1'b0;
      ocMaskEnable_q <= 1'b0;
    end else if (wrLow && index == IdxDriverConfig) begin
      driverEnable_q <= wrByte[BitDriverEnable];
      openLoadEnable_q <= wrByte[BitOpenLoadEnable];
      // R7 mask write guard
      if (!driverEnable_q) begin
        ocMaskEnable_q <= wrByte[BitOcMaskEnable];
      end
    end
  end

  // R12 slew write guard
  always_ff @(posedge clock) begin
    if (reset) begin
      slewRate_q <= 1'b0;
      slewCurrent_q <= 1'b0;
    end else if (wrLow && index == IdxSlewControl && !driverEnable_q) begin
      slewRate_q <= wrByte[BitSlewRate];
      slewCurrent_q <= wrByte[BitSlewCurrent];
    end
  end

  // R13 special-mode write
  always_ff @(posedge clock) begin
    if (reset) begin
      factoryTest_q <= ResetByte;
    end else if (wrLow && index == IdxFactoryTest && specialMode) begin
      factoryTest_q <= wrByte;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ocIrqEnable_q <= 1'b0;
    end else if (wrLow && index == IdxIrqMask) begin
      ocIrqEnable_q <= wrByte[BitOcIrqEnable];
    end
  end

  // R14 flag set wins
  always_ff @(posedge clock) begin
    if (reset) begin
      ocFlag_q <= 1'b0;
    end else if (overcurrentDetect && gateOn_q && !maskActive && !maskStart) begin
      ocFlag_q <= 1'b1;
    end else if (wrLow && index == IdxIrqStatus && wrByte[BitOcFlag]) begin
      ocFlag_q <= 1'b0;
    end
  end

  // R16 stop shutdown
  always_ff @(posedge clock) begin
    if (reset) begin
      stopMode_q <= 1'b0;
      gateOn_q <= 1'b0;
      gateOnPrev_q <= 1'b0;
    end else begin
      stopMode_q <= stopMode;
      // R17 gate equation
      gateOn_q <= driverEnable_q && !stopMode && sourceLevel && !ocFlag_q;
      gateOnPrev_q <= gateOn_q;
    end
  end

  // R6 mask window
  hsd_window_timer #(.Cycles(OcMaskWindow)) u_mask (
    .clock(clock),
    .reset(reset),
    .start(switchOn),
    .enable(ocMaskEnable_q),
    .active(maskActive)
  );
  // R11 slew-rate window
  hsd_window_timer #(.Cycles(SlewRateCycles)) u_rate (
    .clock(clock),
    .reset(reset),
    .start(switchOn),
    .enable(slewRate_q),
    .active(rateActive)
  );
  // R10 slew-current window
  hsd_window_timer #(.Cycles(SlewCurrentCycles)) u_curr (
    .clock(clock),
    .reset(reset),
    .start(switchOn),
    .enable(slewCurrent_q),
    .active(currentActive)
  );

  // R8 open-load gating
  always_ff @(posedge clock) begin
    if (reset) begin
      openLoadActive <= 1'b0;
      openLoad_q <= 1'b0;
    end else begin
      openLoadActive <= openLoadEnable_q && driverEnable_q && !stopMode && !sourceLevel;
      openLoad_q <= openLoadActive && openLoadSense;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge clock) begin
    if (reset) begin
      driverGate <= 1'b0;
      driverBias <= 1'b0;
      slewRateLimit <= 1'b0;
      slewCurrentLimit <= 1'b0;
      factoryTest <= ResetByte;
      irq <= 1'b0;
    end else begin
      driverGate <= driverEnable_q && !stopMode && sourceLevel && !ocFlag_q;
      driverBias <= driverEnable_q && !stopMode;
      slewRateLimit <= rateActive;
      slewCurrentLimit <= currentActive;
      factoryTest <= factoryTest_q;
      // R15 interrupt request
      irq <= ocIrqEnable_q && ocFlag_q;
    end
  end

  // R1 R2 read data
  // R18 unused bits zero
  always_comb begin
    rdByte = ResetByte;
    unique case (index)
      IdxOutputData: rdByte[BitOutputData] = driverEnable_q ? sourceLevel : outputData_q;
      IdxDriverConfig: begin
        rdByte[BitDriverEnable] = driverEnable_q;
        rdByte[BitOpenLoadEnable] = openLoadEnable_q;
        rdByte[BitOcMaskEnable] = ocMaskEnable_q;
      end
      IdxSlewControl: begin
        rdByte[BitSlewRate] = slewRate_q;
        rdByte[BitSlewCurrent] = slewCurrent_q;
      end
      IdxFactoryTest: rdByte = factoryTest_q;
      IdxOpenLoad: rdByte[BitOcFlag] = openLoad_q;
      IdxIrqMask: rdByte[BitOcIrqEnable] = ocIrqEnable_q;
      IdxIrqStatus: rdByte[BitOcFlag] = ocFlag_q;
      default: rdByte = ResetByte;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= (access && mapped && !wb_we_i) ? {24'h00_0000, rdByte} : 32'h0000_0000;
    end
  end

  // R16 stop keeps enable
  // Enable bit is never altered by stop, so it is in force again on exit.

  // R7 mask guarded
  a_mask_guard: assert property (@(posedge clock) disable iff (reset) // R7
    $past(driverEnable_q) && !$past(reset) |-> $stable(ocMaskEnable_q))
    else $error("mask changed while enabled");
  // R12 slew guarded
  a_slew_guard: assert property (@(posedge clock) disable iff (reset) // R12
    $past(driverEnable_q) && !$past(reset) |-> $stable(slewRate_q) && $stable(slewCurrent_q))
    else $error("slew changed while enabled");
  // R3 stop clears data
  a_stop_clear: assert property (@(posedge clock) disable iff (reset) // R3
    stopMode && !stopMode_q |=> !outputData_q)
    else $error("data not cleared at stop");
  // R14 flag blocks gate
  a_flag_offgate: assert property (@(posedge clock) disable iff (reset) // R14
    ocFlag_q |=> !driverGate)
    else $error("gate on with flag set");
  // R15 irq follows flag
  a_irq_follow: assert property (@(posedge clock) disable iff (reset) // R15
    ocIrqEnable_q && ocFlag_q |=> irq)
    else $error("irq missing");
  // R16 stop turns off
  a_stop_off: assert property (@(posedge clock) disable iff (reset) // R16
    stopMode |=> !driverGate && !driverBias)
    else $error("driver on in stop");
  // R8 open-load gating
  a_ol_gate: assert property (@(posedge clock) disable iff (reset) // R8
    openLoadActive |-> $past(driverEnable_q) && $past(openLoadEnable_q) && !$past(sourceLevel))
    else $error("open-load misgated");
  // R11 rate window
  a_rate_len: assert property (@(posedge clock) disable iff (reset) // R11
    slewRate_q && switchOn |=> rateActive [*8])
    else $error("slew window short");
  // R10 current window
  a_cur_len: assert property (@(posedge clock) disable iff (reset) // R10
    slewCurrent_q && switchOn |=> currentActive [*8])
    else $error("current window short");
  // Single-cycle bus answer
  a_ack_once: assert property (@(posedge clock) disable iff (reset)
    wb_ack_o |=> !wb_ack_o && !wb_err_o)
    else $error("ack held");
  // R6 masked detection
  a_mask_window: assert property (@(posedge clock) disable iff (reset) // R6
    !ocFlag_q && (maskActive || maskStart) |=> !ocFlag_q)
    else $error("flag set inside mask window");
  // R14 flag sticky
  a_flag_sticky: assert property (@(posedge clock) disable iff (reset) // R14
    ocFlag_q && !(wrLow && index == IdxIrqStatus && wrByte[BitOcFlag]) |=> ocFlag_q)
    else $error("flag lost without clear");
  // R17 gate needs cause
  a_gate_cond: assert property (@(posedge clock) disable iff (reset) // R17
    driverGate |-> $past(driverEnable_q) && $past(sourceLevel) && !$past(ocFlag_q) && !$past(stopMode))
    else $error("gate on without cause");
  // R9 bias follows enable
  a_bias_cond: assert property (@(posedge clock) disable iff (reset) // R9
    driverBias |-> $past(driverEnable_q) && !$past(stopMode))
    else $error("bias on without enable");
  // R13 test write guard
  a_test_guard: assert property (@(posedge clock) disable iff (reset) // R13
    !$past(specialMode) && !$past(reset) |-> $stable(factoryTest_q))
    else $error("test register written outside special mode");
  // R1 stored bit read
  a_data_read: assert property (@(posedge clock) disable iff (reset) // R1
    wb_ack_o && $past(index) == IdxOutputData && !$past(wb_we_i) && !$past(driverEnable_q)
      |-> wb_dat_o[BitOutputData] == $past(outputData_q))
    else $error("data read not stored bit");
  // R18 upper bits zero
  a_upper_zero: assert property (@(posedge clock) disable iff (reset) // R18
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  c_switch_on: cover property (@(posedge clock) disable iff (reset) switchOn);
  c_oc_flag: cover property (@(posedge clock) disable iff (reset) $rose(ocFlag_q));
  c_masked_oc: cover property (@(posedge clock) disable iff (reset) overcurrentDetect && maskActive);
  c_stop: cover property (@(posedge clock) disable iff (reset) $rose(stopMode_q));
endmodule
`default_nettype wire

/* core/hsd_pkg.sv */
// Purpose: Shared constants for the high-side driver control block
// Assumes: Wishbone classic, 32-bit data, byte addresses, 40 MHz clock
// Notes: Offsets are register index times four
`default_nettype none
package hsd_pkg;
  localparam int ClockMhz = 40;
  // Register indices as printed, byte address is four times the index
  localparam logic [3:0] IdxOutputData = 4'h0;
  localparam logic [3:0] IdxDriverConfig = 4'h1;
  localparam logic [3:0] IdxSlewControl = 4'h2;
  localparam logic [3:0] IdxFactoryTest = 4'h3;
  localparam logic [3:0] IdxSpare = 4'h4;
  localparam logic [3:0] IdxOpenLoad = 4'h5;
  localparam logic [3:0] IdxIrqMask = 4'h6;
  localparam logic [3:0] IdxIrqStatus = 4'h7;
  // Field positions
  localparam int BitOutputData = 0;
  localparam int BitDriverEnable = 0;
  localparam int BitOpenLoadEnable = 2;
  localparam int BitOcMaskEnable = 4;
  localparam int BitSlewRate = 0;
  localparam int BitSlewCurrent = 2;
  localparam int BitOcIrqEnable = 7;
  localparam int BitOcFlag = 0;
  // Reset values
  localparam logic [7:0] ResetByte = 8'h00;
  // Timing in nanoseconds; windows are longest times, rounded down
  localparam int SlewCurrentNs = 4000;
  localparam int SlewRateNs = 8000;
  localparam int OcMaskNs = 2000;
  localparam int SlewCurrentCycles = SlewCurrentNs * ClockMhz / 1000;
  localparam int SlewRateCycles = SlewRateNs * ClockMhz / 1000;
  localparam int OcMaskCycles = OcMaskNs * ClockMhz / 1000;
endpackage
`default_nettype wire

/* core/hsd_window_timer.sv */
// Purpose: One-shot window counter started by the driver switch-on
// Assumes: Start is a one-cycle pulse
// Notes: Active stays high for exactly Cycles clocks after start
`default_nettype none
module hsd_window_timer #(
  parameter int Cycles = 160
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  input wire logic enable,
  output logic active
);
  logic [15:0] count_q;
  always_ff @(posedge clock) begin
    if (reset || !enable) begin
      count_q <= 16'h0000;
    end else if (start) begin
      count_q <= 16'(Cycles);
    end else if (count_q != 16'h0000) begin
      count_q <= count_q - 16'h0001;
    end
  end
  assign active = count_q != 16'h0000;
endmodule
`default_nettype wire

/* verification/hsd_load_model.sv */
// Purpose: Behavioural LED or resistive load on the driver pin
// Assumes: Short and open faults are commanded by the bench
// Notes: Sense toggles while detection is off, so stale values never pass
`default_nettype none
module hsd_load_model (
  input wire logic clock,
  input wire logic driverGate,
  input wire logic openLoadActive,
  input wire logic shortCmd,
  input wire logic openCmd,
  output logic overcurrentDetect,
  output logic openLoadSense
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idleToggle = 1'b0;
  always @(posedge clock) idleToggle <= ~idleToggle;
  // Excess current only flows while the gate is on
  assign overcurrentDetect = driverGate & shortCmd;
  assign openLoadSense = openLoadActive ? openCmd : idleToggle;
endmodule
`default_nettype wire

/* verification/hsd_driver_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the high-side driver control block
// Assumes: Wishbone classic master, one request at a time
// Notes: Mask window shortened to four cycles to keep the run brief
`default_nettype none
module hsd_driver_ctrl_tb_top;
  import hsd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [31:0] adr = '0, wdat = '0, rdat, rd, seed = 32'h0000_0053;
  logic [3:0] sel = '0;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, err, e;
  logic specialMode = 1'b0, stopMode = 1'b0, sourceSelData = 1'b0, routedSource = 1'b0;
  logic shortCmd = 1'b0, openCmd = 1'b0, ocDet, olSense, irq;
  logic driverGate, driverBias, openLoadActive, slewRateLimit, slewCurrentLimit;
  logic [7:0] factoryTest, d;
  int failCount = 0, cmpCount = 0, rateCnt = 0, curCnt = 0, rate0 = 0, cur0 = 0;
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    if (slewRateLimit === 1'b1) rateCnt++;
    if (slewCurrentLimit === 1'b1) curCnt++;
  end
  hsd_driver_ctrl #(.OcMaskWindow(4)) dut (.clock(clock), .reset(reset), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .specialMode(specialMode), .stopMode(stopMode), .sourceSelData(sourceSelData),
    .routedSource(routedSource), .overcurrentDetect(ocDet), .openLoadSense(olSense), .driverGate(driverGate),
    .driverBias(driverBias), .openLoadActive(openLoadActive), .slewRateLimit(slewRateLimit),
    .slewCurrentLimit(slewCurrentLimit), .factoryTest(factoryTest), .irq(irq));
  hsd_load_model load (.clock(clock), .driverGate(driverGate), .openLoadActive(openLoadActive),
    .shortCmd(shortCmd), .openCmd(openCmd), .overcurrentDetect(ocDet), .openLoadSense(olSense));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] dataExp(logic en, logic sd, logic db, logic src);
    return {31'h0, en ? (sd ? db : src) : db};
  endfunction
  task automatic results();
    if (failCount == 0 && cmpCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge clock);
  endtask
  // Held until ack or err is sampled, released at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] dt);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= {24'h00_0000, a};
    wdat <= {24'h00_0000, dt};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 64);
    rd = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 64) begin
      failCount++;
      results();
    end
  endtask
  task automatic waitIrq();
    int n;
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge clock);
      n++;
      if (n > 60) begin
        failCount++;
        results();
      end
    end
  endtask
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, 8'(i * 4), 8'h00);
      chk({31'h0, e}, {31'h0, i == 8});
      chk(rd, 32'h0000_0000);
    end
    d = 8'(rnd());
    wb(1'b1, 8'h00, d);
    wb(1'b0, 8'h00, 8'h00);
    chk(rd, dataExp(1'b0, 1'b0, d[0], 1'b0));
    chk({31'h0, driverGate}, 32'h0000_0000);
    wb(1'b1, 8'h08, 8'h05 | (d & 8'hfa));
    wb(1'b0, 8'h08, 8'h00);
    chk(rd, 32'h0000_0005);
    wb(1'b1, 8'h04, 8'h01);
    cycles(40);
    chk({31'h0, driverBias}, 32'h0000_0001);
    wb(1'b1, 8'h04, 8'h15);
    wb(1'b1, 8'h08, 8'h00);
    wb(1'b0, 8'h04, 8'h00);
    chk(rd, 32'h0000_0005);
    wb(1'b0, 8'h08, 8'h00);
    chk(rd, 32'h0000_0005);
    sourceSelData <= 1'b1;
    @(negedge clock);
    rate0 = rateCnt;
    cur0 = curCnt;
    wb(1'b1, 8'h00, 8'h01);
    cycles(400);
    chk(32'(rateCnt - rate0), 32'(SlewRateCycles));
    chk(32'(curCnt - cur0), 32'(SlewCurrentCycles));
    chk({31'h0, driverGate}, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      d = 8'(rnd());
      sourceSelData <= 1'b0;
      routedSource <= d[0];
      wb(1'b0, 8'h00, 8'h00);
      chk(rd, dataExp(1'b1, 1'b0, 1'b1, d[0]));
      cycles(2);
      chk({31'h0, driverGate}, {31'h0, d[0]});
    end
    sourceSelData <= 1'b1;
    wb(1'b1, 8'h18, 8'h80);
    shortCmd <= 1'b1;
    waitIrq();
    chk({31'h0, driverGate}, 32'h0000_0000);
    wb(1'b0, 8'h1c, 8'h00);
    chk(rd, 32'h0000_0001);
    shortCmd <= 1'b0;
    wb(1'b1, 8'h18, 8'h00);
    cycles(2);
    chk({31'h0, irq}, 32'h0000_0000);
    wb(1'b1, 8'h1c, 8'h01);
    wb(1'b0, 8'h1c, 8'h00);
    chk(rd, 32'h0000_0000);
    cycles(3);
    chk({31'h0, driverGate}, 32'h0000_0001);
    wb(1'b1, 8'h00, 8'h00);
    wb(1'b1, 8'h04, 8'h14);
    wb(1'b1, 8'h04, 8'h15);
    wb(1'b0, 8'h04, 8'h00);
    chk(rd, 32'h0000_0015);
    cycles(40);
    shortCmd <= 1'b1;
    wb(1'b1, 8'h00, 8'h01);
    cycles(3);
    chk({31'h0, driverGate}, 32'h0000_0001);
    cycles(8);
    wb(1'b0, 8'h1c, 8'h00);
    chk(rd, 32'h0000_0001);
    chk({31'h0, driverGate}, 32'h0000_0000);
    shortCmd <= 1'b0;
    wb(1'b1, 8'h1c, 8'h01);
    cycles(3);
    chk({31'h0, driverGate}, 32'h0000_0001);
    openCmd <= 1'b1;
    wb(1'b1, 8'h00, 8'h00);
    cycles(4);
    chk({31'h0, openLoadActive}, 32'h0000_0001);
    wb(1'b0, 8'h14, 8'h00);
    chk(rd, 32'h0000_0001);
    openCmd <= 1'b0;
    wb(1'b1, 8'h00, 8'h01);
    stopMode <= 1'b1;
    cycles(3);
    chk({30'h0, driverBias, driverGate}, 32'h0000_0000);
    stopMode <= 1'b0;
    cycles(3);
    chk({31'h0, driverBias}, 32'h0000_0001);
    wb(1'b0, 8'h00, 8'h00);
    chk(rd, 32'h0000_0000);
    d = 8'(rnd()) | 8'h01;
    wb(1'b1, 8'h0c, d);
    wb(1'b0, 8'h0c, 8'h00);
    chk(rd, 32'h0000_0000);
    specialMode <= 1'b1;
    wb(1'b1, 8'h0c, d);
    wb(1'b0, 8'h0c, 8'h00);
    chk(rd, {24'h00_0000, d});
    chk({24'h00_0000, factoryTest}, {24'h00_0000, d});
    wb(1'b1, 8'h10, 8'hff);
    wb(1'b0, 8'h10, 8'h00);
    chk(rd, 32'h0000_0000);
    results();
  end
endmodule
`default_nettype wire
